//--- hdl/cred_pkg.sv
// Constants, types and CRC helpers for the configuration RAM CRC error detector.
// Assumes one 100 MHz clock and a configuration RAM read port on that same clock.
// Summary of operation
// - During load, check each frame's CRC against the streamed CRC; stop on mismatch.
// - Load stores sixteen computed check bits per frame in a one-entry-per-frame array.
// - In user mode, recompute frame CRCs continuously until restart is driven low.
// - User-mode checking runs only when the enable option is set at user-mode entry.
// - One 16-bit check per frame; clean frame gives zero signature, flag low once error info is read.
// - A non-zero signature starts a search for the erroneous bit position unless error info is still unread.
// - Error flag output goes high when a frame check finds corruption.
// - Every one, two or three bit error within a frame is detected.
// - Report position and type for single and adjacent double errors; others unguaranteed.
// - Checking continues over following frames after an error is found.
// - Signatures use the standard 16-bit ANSI CRC polynomial.
// - Memory blocks and I/O flops unchecked; flag stays high until error info is read and a frame checks clean.
// - Instruction code 00 0001 0101 selects the 21-bit fault injection register.
// - Fault injection instruction is honoured only in user mode.
// - A loaded type 01 or 10 injection enters error test mode, in which readback bits are flipped.
// - Injection touches only the first frame; error information is readable anytime.
// - Injection register: type 20:19, byte location 18:8, error byte 7:0.
// - Types 01 and 10 enter test mode; error byte picks flipped bits; 00 and 11 leave test mode as it was.
package cred_pkg;

	localparam int          FRAME_BITS = 256;
	localparam int          NUM_FRAMES = 64;
	localparam int          BIT_W      = 8;
	localparam int          FRAME_AW   = 6;
	localparam int          POS_W      = 9;
	localparam int          CW_BITS    = FRAME_BITS + 16;
	localparam logic [15:0] CRC_POLY   = 16'h8005;
	localparam logic [15:0] CRC_INIT   = 16'h0000;
	localparam logic [9:0]  IR_FAULT_INJECT = 10'h015;
	// Arbitrary code for the error-information shift instruction
	localparam logic [9:0]  IR_SHIFT_ERROR  = 10'h017;
	localparam logic [1:0]  INJ_SINGLE = 2'h1;
	localparam logic [1:0]  INJ_DOUBLE = 2'h2;

	typedef enum logic [1:0] {ERR_NONE, ERR_SINGLE, ERR_DOUBLE_ADJ, ERR_OTHER} cred_err_e;

	typedef struct packed {
		logic [1:0]  inj_type;
		logic [10:0] byte_loc;
		logic [7:0]  err_byte;
	} cred_fault_s;

	typedef struct packed {
		logic [FRAME_AW-1:0] frame;
		logic [POS_W-1:0]    pos;
		cred_err_e           kind;
		logic [15:0]         signature;
	} cred_emr_s;

	localparam cred_fault_s FAULT_RESET = '0;
	localparam cred_emr_s   EMR_RESET   = '0;

	function automatic logic [15:0] cred_crc_step(input logic [15:0] c, input logic b);
		cred_crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
	endfunction

endpackage

//--- hdl/cred_checker.sv
// Configuration RAM CRC checker: load-time frame check, user-mode scrubbing,
// error location search, error message register and fault injection.
// Assumes the configuration stream, the RAM read port and the JTAG update
// strobe all run on sys_clk; only config_restart_n comes from a pin.
`timescale 1ns/1ps
module cred_checker
	import cred_pkg::*;
(
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rst,
	input  wire logic                      config_restart_n,
	// Configuration stream
	input  wire logic                      cfg_bit_valid,
	input  wire logic                      cfg_bit,
	input  wire logic                      cfg_crc_valid,
	input  wire logic [15:0]               cfg_crc,
	input  wire logic                      cfg_load_done,
	input  wire logic                      ed_enable_opt,
	output logic                           cfg_crc_fail,
	output logic                           user_mode,
	// Configuration RAM readback
	output logic [FRAME_AW+BIT_W-1:0]      cram_addr,
	output logic                           cram_rd,
	input  wire logic                      cram_data,
	// JTAG and core access
	input  wire logic                      jtag_update,
	input  wire logic [9:0]                jtag_ir,
	input  wire logic [20:0]               jtag_dr,
	input  wire logic                      core_emr_read,
	output cred_fault_s                    fault_injection_control,
	output logic                           error_test_mode,
	output cred_emr_s                      error_message_reg,
	output logic                           emr_out_valid,
	output logic                           emr_pending,
	// Error flag
	output logic                           crc_error
);

	typedef enum logic [2:0] {ST_LOAD, ST_LOAD_FAIL, ST_OFF, ST_READ, ST_EVAL, ST_SEARCH} cred_state_e;

	logic [15:0]          check_mem [NUM_FRAMES];
	cred_state_e          state_q,     state_d;
	logic                 rs1_q,       rs2_q;
	logic [15:0]          crc_q,       crc_d;
	logic [FRAME_AW-1:0]  frame_q,     frame_d;
	logic [BIT_W-1:0]     bit_q,       bit_d;
	logic                 issued_q,    issued_d;
	logic                 feed_q,      feed_d;
	logic [BIT_W-1:0]     feed_idx_q,  feed_idx_d;
	logic [15:0]          sig_q,       sig_d;
	logic [15:0]          srch_q,      srch_d;
	logic [POS_W-1:0]     pos_q,       pos_d;
	logic                 flag_q,      flag_d;
	logic                 full_q,      full_d;
	cred_emr_s            emr_q,       emr_d;
	cred_emr_s            emr_out_q,   emr_out_d;
	logic                 out_vld_q,   out_vld_d;
	cred_fault_s          fi_q,        fi_d;
	logic                 test_q,      test_d;
	logic                 fail_q,      fail_d;
	logic                 user_q,      user_d;
	logic [FRAME_AW+BIT_W-1:0] addr_q, addr_d;
	logic                 rd_q,        rd_d;
	logic                 mem_we;
	logic [15:0]          stored;
	logic [15:0]          signature;
	logic [15:0]          srch_next;
	logic                 inj_flip;
	logic                 rd_req;

	// Restart comes from a pin: two flops before any use
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
		end else begin
			rs1_q <= config_restart_n;
			rs2_q <= rs1_q;
		end
	end

	assign mem_we = (state_q == ST_LOAD) && cfg_crc_valid;
	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			check_mem[frame_q] <= crc_q;
		end
	end

	assign stored    = check_mem[frame_q];
	// Signature is zero for clean frame
	assign signature = crc_q ^ stored;
	assign srch_next = cred_crc_step(srch_q, 1'b0);
	assign inj_flip  = test_q && (frame_q == '0) &&
		({6'h00, feed_idx_q[BIT_W-1:3]} == fi_q.byte_loc) && fi_q.err_byte[feed_idx_q[2:0]];
	assign rd_req    = (jtag_update && (jtag_ir == IR_SHIFT_ERROR)) || core_emr_read;

	always_comb begin
		state_d    = state_q;
		crc_d      = crc_q;
		frame_d    = frame_q;
		bit_d      = bit_q;
		issued_d   = issued_q;
		feed_d     = 1'b0;
		feed_idx_d = feed_idx_q;
		sig_d      = sig_q;
		srch_d     = srch_q;
		pos_d      = pos_q;
		flag_d     = flag_q;
		full_d     = full_q;
		emr_d      = emr_q;
		emr_out_d  = emr_out_q;
		out_vld_d  = 1'b0;
		fi_d       = fi_q;
		test_d     = test_q;
		fail_d     = fail_q;
		user_d     = user_q;
		addr_d     = addr_q;
		rd_d       = 1'b0;

		// Error information is readable in any state
		if (rd_req) begin
			emr_out_d = emr_q;
			out_vld_d = 1'b1;
			full_d    = 1'b0;
		end

		if (jtag_update && (jtag_ir == IR_FAULT_INJECT) && user_q) begin
			fi_d = cred_fault_s'(jtag_dr);
			if ((jtag_dr[20:19] == INJ_SINGLE) || (jtag_dr[20:19] == INJ_DOUBLE)) begin
				test_d = 1'b1;
			end
		end

		case (state_q)
			ST_LOAD: begin
				if (cfg_bit_valid) begin
					crc_d = cred_crc_step(crc_q, cfg_bit);
				end else if (cfg_crc_valid) begin
					crc_d   = CRC_INIT;
					frame_d = FRAME_AW'(frame_q + 1'b1);
					if (cfg_crc != crc_q) begin
						fail_d  = 1'b1;
						state_d = ST_LOAD_FAIL;
					end
				end else if (cfg_load_done) begin
					user_d  = 1'b1;
					frame_d = '0;
					bit_d   = '0;
					state_d = ed_enable_opt ? ST_READ : ST_OFF;
				end
			end
			ST_LOAD_FAIL: begin
				state_d = ST_LOAD_FAIL;
			end
			ST_OFF: begin
				state_d = ST_OFF;
			end
			ST_READ: begin
				if (!issued_q) begin
					rd_d       = 1'b1;
					addr_d     = {frame_q, bit_q};
					feed_d     = 1'b1;
					feed_idx_d = bit_q;
					bit_d      = BIT_W'(bit_q + 1'b1);
					issued_d   = (bit_q == BIT_W'(FRAME_BITS - 1));
				end else if (!feed_q) begin
					state_d = ST_EVAL;
				end
				if (feed_q) begin
					crc_d = cred_crc_step(crc_q, cram_data ^ inj_flip);
				end
			end
			ST_EVAL: begin
				state_d  = ST_READ;
				crc_d    = CRC_INIT;
				bit_d    = '0;
				issued_d = 1'b0;
				frame_d  = FRAME_AW'(frame_q + 1'b1);
				if (signature == 16'h0000) begin
					// Clear only once info was read
					if (!full_d) begin
						flag_d = 1'b0;
					end
				end else begin
					flag_d = 1'b1;
					if (!full_q) begin
						sig_d   = signature;
						srch_d  = 16'h0001;
						pos_d   = '0;
						frame_d = frame_q;
						state_d = ST_SEARCH;
					end
				end
			end
			ST_SEARCH: begin
				if ((srch_q == sig_q) || ((srch_q ^ srch_next) == sig_q) ||
				    (pos_q == POS_W'(CW_BITS - 1))) begin
					emr_d.frame     = frame_q;
					emr_d.pos       = pos_q;
					emr_d.signature = sig_q;
					if (srch_q == sig_q) begin
						emr_d.kind = ERR_SINGLE;
					end else if ((srch_q ^ srch_next) == sig_q) begin
						emr_d.kind = ERR_DOUBLE_ADJ;
					end else begin
						emr_d.kind = ERR_OTHER;
					end
					// New capture wins over a read in the same cycle
					full_d = 1'b1;
					frame_d = FRAME_AW'(frame_q + 1'b1);
					state_d = ST_READ;
				end else begin
					srch_d = srch_next;
					pos_d  = POS_W'(pos_q + 1'b1);
				end
			end
			default: begin
				state_d = ST_LOAD;
			end
		endcase

		if (!rs2_q) begin
			state_d  = ST_LOAD;
			crc_d    = CRC_INIT;
			frame_d  = '0;
			bit_d    = '0;
			issued_d = 1'b0;
			feed_d   = 1'b0;
			flag_d   = 1'b0;
			full_d   = 1'b0;
			emr_d    = EMR_RESET;
			fi_d     = FAULT_RESET;
			test_d   = 1'b0;
			fail_d   = 1'b0;
			user_d   = 1'b0;
			rd_d     = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q    <= ST_LOAD;
			crc_q      <= CRC_INIT;
			frame_q    <= '0;
			bit_q      <= '0;
			issued_q   <= 1'b0;
			feed_q     <= 1'b0;
			feed_idx_q <= '0;
			sig_q      <= '0;
			srch_q     <= '0;
			pos_q      <= '0;
			flag_q     <= 1'b0;
			full_q     <= 1'b0;
			emr_q      <= EMR_RESET;
			emr_out_q  <= EMR_RESET;
			out_vld_q  <= 1'b0;
			fi_q       <= FAULT_RESET;
			test_q     <= 1'b0;
			fail_q     <= 1'b0;
			user_q     <= 1'b0;
			addr_q     <= '0;
			rd_q       <= 1'b0;
		end else begin
			state_q    <= state_d;
			crc_q      <= crc_d;
			frame_q    <= frame_d;
			bit_q      <= bit_d;
			issued_q   <= issued_d;
			feed_q     <= feed_d;
			feed_idx_q <= feed_idx_d;
			sig_q      <= sig_d;
			srch_q     <= srch_d;
			pos_q      <= pos_d;
			flag_q     <= flag_d;
			full_q     <= full_d;
			emr_q      <= emr_d;
			emr_out_q  <= emr_out_d;
			out_vld_q  <= out_vld_d;
			fi_q       <= fi_d;
			test_q     <= test_d;
			fail_q     <= fail_d;
			user_q     <= user_d;
			addr_q     <= addr_d;
			rd_q       <= rd_d;
		end
	end

	assign crc_error               = flag_q;
	assign cfg_crc_fail            = fail_q;
	assign user_mode               = user_q;
	assign cram_addr               = addr_q;
	assign cram_rd                 = rd_q;
	assign fault_injection_control = fi_q;
	assign error_test_mode         = test_q;
	assign error_message_reg       = emr_out_q;
	assign emr_out_valid           = out_vld_q;
	assign emr_pending             = full_q;

endmodule

//--- test/cred_checker_props.sv
// Port assertions for the configuration RAM CRC checker.
// Assumes it is bound to cred_checker and sees only its ports.
`timescale 1ns/1ps
module cred_checker_props
	import cred_pkg::*;
(
	// Clock and reset
	input wire logic                      sys_clk,
	input wire logic                      rst,
	input wire logic                      config_restart_n,
	// Load and readback
	input wire logic                      cfg_crc_valid,
	input wire logic                      cfg_load_done,
	input wire logic                      cfg_crc_fail,
	input wire logic                      user_mode,
	input wire logic [FRAME_AW+BIT_W-1:0] cram_addr,
	input wire logic                      cram_rd,
	// Access and flag
	input wire logic                      jtag_update,
	input wire logic [9:0]                jtag_ir,
	input wire logic [20:0]               jtag_dr,
	input wire logic                      core_emr_read,
	input wire cred_fault_s               fault_injection_control,
	input wire logic                      error_test_mode,
	input wire logic                      emr_out_valid,
	input wire logic                      emr_pending,
	input wire logic                      crc_error
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic inj_w;
	logic rd_w;
	assign inj_w = jtag_update && jtag_ir == IR_FAULT_INJECT && user_mode;
	assign rd_w = core_emr_read || (jtag_update && jtag_ir == IR_SHIFT_ERROR);
	chk_user_entry:
	assert property ($rose(user_mode) |-> $past(cfg_load_done)) else $error("user mode without load done");
	chk_fail_cause:
	assert property ($rose(cfg_crc_fail) |-> $past(cfg_crc_valid)) else $error("load fail without crc");
	chk_read_user:
	assert property (cram_rd |-> user_mode) else $error("readback outside user mode");
	chk_scan_step:
	assert property (cram_rd && $past(cram_rd) |-> cram_addr == $past(cram_addr) + 1'b1) else $error("scan skipped");
	chk_inj_load:
	assert property (inj_w |=> fault_injection_control == $past(jtag_dr)) else $error("injection not loaded");
	chk_inj_mode:
	assert property (inj_w |=> error_test_mode == ($past(error_test_mode) || $past(jtag_dr[20:19]) == INJ_SINGLE
		|| $past(jtag_dr[20:19]) == INJ_DOUBLE)) else $error("test mode decode wrong");
	chk_emr_read:
	assert property (rd_w |=> emr_out_valid) else $error("read not answered");
	chk_flag_holds:
	assert property (config_restart_n [*4] ##0 (crc_error && emr_pending && !rd_w) |=> crc_error) else $error("flag dropped");
	cover property ($rose(crc_error));
	cover property ($rose(error_test_mode));
	cover property (emr_out_valid);
endmodule

bind cred_checker cred_checker_props cred_checker_props_i (.sys_clk, .rst, .config_restart_n, .cfg_crc_valid,
	.cfg_load_done, .cfg_crc_fail, .user_mode, .cram_addr, .cram_rd, .jtag_update, .jtag_ir, .jtag_dr,
	.core_emr_read, .fault_injection_control, .error_test_mode, .emr_out_valid, .emr_pending, .crc_error);

//--- test/cred_cram_model.sv
// Behavioural configuration RAM, one bit per address.
// Assumes the bench writes it while loading and to flip bits.
`timescale 1ns/1ps
module cred_cram_model
	import cred_pkg::*;
(
	// Clock and bench write port
	input wire logic                      sys_clk,
	input wire logic                      wr,
	input wire logic [FRAME_AW+BIT_W-1:0] wr_addr,
	input wire logic                      wr_bit,
	// Readback port
	input wire logic [FRAME_AW+BIT_W-1:0] cram_addr,
	input wire logic                      cram_rd,
	output logic                          cram_data
);
	logic mem [NUM_FRAMES*FRAME_BITS];
	logic rd_q;
	logic last_q = 1'b0;
	always @(posedge sys_clk) begin
		if (wr)
			mem[wr_addr] <= wr_bit;
		rd_q <= cram_rd;
		if (rd_q)
			last_q <= cram_data;
	end
	// Outside a read the line shows the inverse, so stale data never looks right
	assign cram_data = (cram_rd || rd_q) ? mem[cram_addr] : ~last_q;
endmodule

//--- test/config_ram_crc_error_detect_tb_top.sv
// Self-checking bench for the configuration RAM CRC checker.
// Assumes cred_cram_model stands in for the configuration RAM.
`timescale 1ns/1ps
module config_ram_crc_error_detect_tb_top;
	import cred_pkg::*;
	logic sys_clk, rst, config_restart_n, cfg_bit_valid, cfg_bit, cfg_crc_valid, cfg_load_done, ed_enable_opt;
	logic cfg_crc_fail, user_mode, cram_rd, cram_data, jtag_update, core_emr_read, wr, wr_bit;
	logic error_test_mode, emr_out_valid, emr_pending, crc_error;
	logic [15:0] cfg_crc;
	logic [FRAME_AW+BIT_W-1:0] cram_addr, wr_addr;
	logic [9:0] jtag_ir;
	logic [20:0] jtag_dr;
	logic [1:0] t;
	cred_fault_s fault_injection_control;
	cred_emr_s error_message_reg;
	int mem_m [NUM_FRAMES*FRAME_BITS];
	int mismatches = 0, compares = 0, cycles = 0, seed, f, b, sig, bad;

	cred_checker cred_checker_i (.sys_clk, .rst, .config_restart_n, .cfg_bit_valid, .cfg_bit, .cfg_crc_valid,
		.cfg_crc, .cfg_load_done, .ed_enable_opt, .cfg_crc_fail, .user_mode, .cram_addr, .cram_rd, .cram_data,
		.jtag_update, .jtag_ir, .jtag_dr, .core_emr_read, .fault_injection_control, .error_test_mode,
		.error_message_reg, .emr_out_valid, .emr_pending, .crc_error);
	cred_cram_model cred_cram_model_i (.sys_clk, .wr, .wr_addr, .wr_bit, .cram_addr, .cram_rd, .cram_data);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("Compares %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Serial MSB-first CRC, x16+x15+x2+1, zero start
	function automatic int crc_of(input int fr);
		int c;
		c = 0;
		for (int i = 0; i < FRAME_BITS; i++)
			c = ((c << 1) & 32'h0000FFFF) ^ ((((c >> 15) & 1) ^ mem_m[fr * FRAME_BITS + i]) ? 32'h00008005 : 0);
		return c;
	endfunction

	task automatic send_frame(input int fr, input int crc);
		for (int i = 0; i < FRAME_BITS; i++) begin
			@(posedge sys_clk);
			cfg_bit_valid <= 1'b1;
			cfg_bit <= mem_m[fr * FRAME_BITS + i][0];
			wr <= 1'b1;
			wr_addr <= (FRAME_AW+BIT_W)'(fr * FRAME_BITS + i);
			wr_bit <= mem_m[fr * FRAME_BITS + i][0];
		end
		@(posedge sys_clk);
		{cfg_bit_valid, wr, cfg_crc_valid} <= 3'h1;
		cfg_crc <= crc[15:0];
		@(posedge sys_clk);
		cfg_crc_valid <= 1'b0;
	endtask

	task automatic pulse_done;
		@(posedge sys_clk);
		cfg_load_done <= 1'b1;
		@(posedge sys_clk);
		cfg_load_done <= 1'b0;
		#1;
	endtask

	task automatic flip(input int a);
		mem_m[a] ^= 1;
		@(posedge sys_clk);
		wr <= 1'b1;
		wr_addr <= a[13:0];
		wr_bit <= mem_m[a][0];
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask

	task automatic access(input logic core, input logic [9:0] ir, input logic [20:0] dr);
		@(posedge sys_clk);
		core_emr_read <= core;
		jtag_update <= ~core;
		jtag_ir <= ir;
		jtag_dr <= dr;
		@(posedge sys_clk);
		{core_emr_read, jtag_update} <= 2'h0;
		#1;
	endtask

	task automatic wait_until(input int sel);
		int n;
		n = 0;
		while ((sel ? crc_error !== 1'b0 : emr_pending !== 1'b1) && n < 20000) begin
			@(posedge sys_clk);
			n++;
		end
		#1;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 99000) begin
			mismatches++;
			tally_and_finish;
		end
	end

	initial begin
		{rst, config_restart_n, ed_enable_opt} = 3'h7;
		{cfg_bit_valid, cfg_bit, cfg_crc_valid, cfg_load_done, jtag_update, core_emr_read, wr, wr_bit} = 8'h00;
		{cfg_crc, wr_addr, jtag_ir, jtag_dr} = '0;
		seed = 32'h86176A46;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		access(1'b0, IR_FAULT_INJECT, 21'h080310);
		check(fault_injection_control, 0);
		for (f = 0; f < NUM_FRAMES; f++) begin
			for (b = 0; b < FRAME_BITS; b++)
				mem_m[f * FRAME_BITS + b] = $random(seed) & 1;
			send_frame(f, crc_of(f));
		end
		#1;
		check(cfg_crc_fail, 0);
		pulse_done();
		check(user_mode, 1);
		bad = 0;
		repeat (17000) begin
			@(posedge sys_clk);
			if (crc_error !== 1'b0)
				bad = 1;
		end
		check(bad, 0);
		// Single error read by the core, then double-adjacent read over JTAG
		for (int k = 0; k < 2; k++) begin
			f = 5 + 4 * k;
			b = f * FRAME_BITS + 100 - 60 * k;
			sig = crc_of(f);
			// Keep the scan away while a double error is half written
			while (cram_addr[FRAME_AW+BIT_W-1:BIT_W] == f || cram_addr[FRAME_AW+BIT_W-1:BIT_W] == f - 1)
				@(posedge sys_clk);
			flip(b);
			if (k == 1)
				flip(b + 1);
			sig ^= crc_of(f);
			wait_until(0);
			check(crc_error, 1);
			flip(b);
			if (k == 1)
				flip(b + 1);
			access(k == 0, IR_SHIFT_ERROR, 21'h000000);
			check(emr_pending, 0);
			check(emr_out_valid, 1);
			check(error_message_reg.frame, f);
			check(error_message_reg.pos, 271 - (b % FRAME_BITS) - k);
			check(error_message_reg.kind, k ? ERR_DOUBLE_ADJ : ERR_SINGLE);
			check(error_message_reg.signature, sig);
			check(crc_error, 1);
			wait_until(1);
			check(crc_error, 0);
		end
		// Types in order 11, 00, 10, 01
		for (int i = 3; i >= 0; i--) begin
			t = 2'(8'hC9 >> (2 * i));
			access(1'b0, IR_FAULT_INJECT, {t, 11'h003, 8'h10});
			check(fault_injection_control, {t, 11'h003, 8'h10});
			check(error_test_mode, i < 2);
		end
		wait_until(0);
		access(1'b0, IR_SHIFT_ERROR, 21'h000000);
		check(error_message_reg.frame, 0);
		check(error_message_reg.pos, 243);
		@(posedge sys_clk);
		config_restart_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		config_restart_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		check(user_mode, 0);
		check(error_test_mode, 0);
		send_frame(0, crc_of(0) ^ 1);
		#1;
		check(cfg_crc_fail, 1);
		pulse_done();
		check(user_mode, 0);
		// Option off: user mode is entered but nothing is scanned
		@(posedge sys_clk);
		config_restart_n <= 1'b0;
		ed_enable_opt <= 1'b0;
		repeat (3) @(posedge sys_clk);
		config_restart_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		pulse_done();
		check(user_mode, 1);
		bad = 0;
		repeat (600) begin
			@(posedge sys_clk);
			if (cram_rd !== 1'b0 || crc_error !== 1'b0)
				bad = 1;
		end
		check(bad, 0);
		tally_and_finish;
	end
endmodule
